// ---- src/uhfc_pkg.sv ----
package uhfc_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_DIVISOR = 8'h04;
    localparam logic [7:0] OFF_FIFO_CTRL = 8'h08;
    localparam logic [7:0] OFF_MODEM_CTRL = 8'h10;
    localparam logic [7:0] OFF_MODEM_STATUS = 8'h18;
    localparam logic [7:0] OFF_RX_LEVEL = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
    localparam logic [7:0] OFF_CTS_IRQ_CTRL = 8'h2c;
    // Field positions.
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_AUTO_RTS_BIT = 6;
    localparam int MCR_AUTO_CTS_BIT = 7;
    localparam int MSR_DELTA_CTS_BIT = 0;
    localparam int MSR_CTS_BIT = 4;
    localparam int FCR_TRIG_LSB = 6;
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_MODEM = 2;
    localparam int IRQ_OVERRUN = 3;
    localparam int NIRQ = 4;
    // Values after reset.
    localparam logic [15:0] DIVISOR_RESET = 16'h006c;
    localparam logic [1:0] TRIG_RESET = 2'h0;
    localparam logic MCR_BIT_RESET = 1'b0;
    localparam logic [NIRQ-1:0] IRQ_RESET = 4'h0;
    // Receive trigger levels and the level below each one, in bytes.
    localparam logic [4:0] TRIG_LEVEL [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    localparam logic [4:0] TRIG_PREV [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
    // Bits in a character frame after the start bit: eight data and one stop.
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [2:0] RX_LAST_DATA = 3'h7;
endpackage

// ---- src/uhfc_sync.sv ----
`timescale 1ns/1ps
module uhfc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// ---- src/uhfc_flow_uart.sv ----
// What this block does
// [R1] Modem control bit 6 resets to zero and turns automatic RTS on when set.
// [R2] Modem control bit 7 resets to zero and turns automatic CTS on when set.
// [R3] Software writes zero to reserved modem control bit 5 and ignores its read value.
// [R4] With automatic RTS on, RTS goes high once the receive fill level reaches the trigger.
// [R5] With automatic RTS on, RTS goes low again once the fill level drops to the lower level.
// [R6] A byte arriving after RTS went high is still stored normally.
// [R7] With automatic RTS off, the RTS pin follows the software RTS control bit.
// [R8] With automatic RTS on, the RTS control bit mirrors the real RTS pin state.
// [R9] With automatic RTS on, software writes to the RTS control bit are ignored.
// [R10] With automatic CTS on, a character starts only when CTS is sampled low.
// [R11] The far end raises CTS before mid stop bit to hold back the next character.
// [R12] With automatic CTS on, a CTS change interrupts only if the CTS interrupt enable is set.
// [R13] Every CTS change sets the delta CTS flag in the modem status register.
// [R14] With CTS flow on and its interrupt enable clear, a CTS change never interrupts.
// [R15] While held back by CTS the line idles at one, then resumes with a start bit.
// [R16] With automatic CTS off, the transmitter ignores CTS and sends pending data.
`timescale 1ns/1ps
module uhfc_flow_uart
    import uhfc_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic ctsN,
    output logic rtsN,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uhfc_rx_e;

    logic rxdS, ctsHigh;
    logic accDone, wrEn, rdEn, hit;
    logic [31:0] rdMux;
    logic [15:0] div_q;
    logic [1:0] trigSel_q;
    logic autoRts_q, autoCts_q, rtsCtrl_q, rtsOff_q;
    logic [NIRQ-1:0] irqEn_q, irqStatus_q, irqEvent;
    logic ctsIrqEn_q, ctsPrev_q, deltaCts_q, ctsEdge;
    logic [7:0] fifoMem [DEPTH];
    logic [PW-1:0] wrPtr_q, rdPtr_q;
    logic [CW-1:0] rxCount_q;
    logic rxPush, rxPop, rxOverrun, fifoFull;
    uhfc_rx_e rxState_q;
    logic [15:0] rxCnt_q;
    logic [2:0] rxBit_q;
    logic [7:0] rxSh_q;
    logic rxDone_q;
    logic [7:0] txHold_q;
    logic txFull_q, txBusy_q, txStart, txDone_q;
    logic [8:0] txSh_q;
    logic [3:0] txBit_q;
    logic [15:0] txCnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    uhfc_sync #(.W(2), .RST_VAL(2'h3)) pinSync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn({rxd, ctsN}),
        .syncOut({rxdS, ctsHigh})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // The slave inserts one wait state; effects happen at the completing edge.
    assign accDone = psel && penable && pready;
    assign wrEn = accDone && pwrite;
    assign rdEn = accDone && !pwrite;

    always_comb begin
        rdMux = 32'h0;
        hit = (paddr[1:0] == 2'h0);
        case (paddr)
            OFF_DATA: rdMux[7:0] = fifoMem[rdPtr_q];
            OFF_DIVISOR: rdMux[15:0] = div_q;
            OFF_FIFO_CTRL: rdMux[FCR_TRIG_LSB+:2] = trigSel_q;
            OFF_MODEM_CTRL: begin
                rdMux[MCR_RTS_BIT] = rtsCtrl_q;
                rdMux[MCR_AUTO_RTS_BIT] = autoRts_q;
                rdMux[MCR_AUTO_CTS_BIT] = autoCts_q;
            end
            OFF_MODEM_STATUS: begin
                rdMux[MSR_DELTA_CTS_BIT] = deltaCts_q;
                rdMux[MSR_CTS_BIT] = !ctsHigh;
            end
            OFF_RX_LEVEL: rdMux[CW-1:0] = rxCount_q;
            OFF_IRQ_STATUS: rdMux[NIRQ-1:0] = irqStatus_q;
            OFF_IRQ_CLEAR: rdMux = 32'h0;
            OFF_IRQ_ENABLE: rdMux[NIRQ-1:0] = irqEn_q;
            OFF_CTS_IRQ_CTRL: rdMux[0] = ctsIrqEn_q;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !hit;
            prdata <= (pwrite || !hit) ? 32'h0 : rdMux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reserved modem control bits are not stored and read as zero.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= DIVISOR_RESET;
            trigSel_q <= TRIG_RESET;
            autoRts_q <= MCR_BIT_RESET; // R1
            autoCts_q <= MCR_BIT_RESET; // R2
            irqEn_q <= IRQ_RESET;
            ctsIrqEn_q <= 1'b0;
        end else if (wrEn && hit) begin
            case (paddr)
                OFF_DIVISOR: div_q <= pwdata[15:0];
                OFF_FIFO_CTRL: trigSel_q <= pwdata[FCR_TRIG_LSB+:2];
                OFF_MODEM_CTRL: begin
                    autoRts_q <= pwdata[MCR_AUTO_RTS_BIT]; // R1
                    autoCts_q <= pwdata[MCR_AUTO_CTS_BIT]; // R2
                end
                OFF_IRQ_ENABLE: irqEn_q <= pwdata[NIRQ-1:0];
                OFF_CTS_IRQ_CTRL: ctsIrqEn_q <= pwdata[0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rtsCtrl_q <= MCR_BIT_RESET;
        end else if (autoRts_q) begin
            rtsCtrl_q <= !rtsOff_q; // R8 R9
        end else if (wrEn && paddr == OFF_MODEM_CTRL) begin
            rtsCtrl_q <= pwdata[MCR_RTS_BIT];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rtsOff_q <= 1'b0;
        end else if (!autoRts_q) begin
            rtsOff_q <= 1'b0;
        end else if (rxCount_q >= CW'(TRIG_LEVEL[trigSel_q])) begin
            rtsOff_q <= 1'b1; // R4
        end else if (rxCount_q <= CW'(TRIG_PREV[trigSel_q])) begin
            rtsOff_q <= 1'b0; // R5
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rtsN <= 1'b1;
        end else begin
            rtsN <= autoRts_q ? rtsOff_q : !rtsCtrl_q; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The receive FIFO takes every complete byte while it has room, RTS or not.
    assign fifoFull = (rxCount_q == CW'(DEPTH));
    assign rxPush = rxDone_q && !fifoFull; // R6
    assign rxOverrun = rxDone_q && fifoFull;
    assign rxPop = rdEn && paddr == OFF_DATA && rxCount_q != '0;

    always_ff @(posedge mclk) begin
        if (rxPush) begin
            fifoMem[wrPtr_q] <= rxSh_q;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            rxCount_q <= '0;
        end else begin
            if (rxPush) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (rxPop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            if (rxPush && !rxPop) begin
                rxCount_q <= rxCount_q + 1'b1;
            end else if (rxPop && !rxPush) begin
                rxCount_q <= rxCount_q - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One bit lasts div_q cycles; the start bit is checked at its middle.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rxState_q <= RX_IDLE;
            rxCnt_q <= 16'h0;
            rxBit_q <= 3'h0;
            rxSh_q <= 8'h0;
            rxDone_q <= 1'b0;
        end else begin
            rxDone_q <= 1'b0;
            if (rxState_q != RX_IDLE && rxCnt_q != 16'h0) begin
                rxCnt_q <= rxCnt_q - 1'b1;
            end else begin
                case (rxState_q)
                    RX_IDLE: if (!rxdS) begin
                        rxState_q <= RX_START;
                        rxCnt_q <= {1'b0, div_q[15:1]};
                    end
                    RX_START: begin
                        rxState_q <= rxdS ? RX_IDLE : RX_DATA;
                        rxCnt_q <= div_q - 1'b1;
                        rxBit_q <= 3'h0;
                    end
                    RX_DATA: begin
                        rxSh_q <= {rxdS, rxSh_q[7:1]};
                        rxCnt_q <= div_q - 1'b1;
                        rxBit_q <= rxBit_q + 1'b1;
                        if (rxBit_q == RX_LAST_DATA) begin
                            rxState_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        rxDone_q <= rxdS;
                        rxState_q <= RX_IDLE;
                    end
                    default: rxState_q <= RX_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // CTS is looked at only between characters, so a frame is never cut short.
    assign txStart = !txBusy_q && txFull_q && (!autoCts_q || !ctsHigh); // R10 R16

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            txHold_q <= 8'h0;
            txFull_q <= 1'b0;
        end else if (txStart) begin
            txFull_q <= 1'b0;
        end else if (wrEn && paddr == OFF_DATA && !txFull_q) begin
            txHold_q <= pwdata[7:0];
            txFull_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            txBusy_q <= 1'b0;
            txd <= 1'b1;
            txSh_q <= 9'h1ff;
            txBit_q <= 4'h0;
            txCnt_q <= 16'h0;
            txDone_q <= 1'b0;
        end else begin
            txDone_q <= 1'b0;
            if (txStart) begin
                txBusy_q <= 1'b1;
                txd <= 1'b0; // R15
                txSh_q <= {1'b1, txHold_q};
                txBit_q <= 4'h0;
                txCnt_q <= div_q - 1'b1;
            end else if (!txBusy_q) begin
                txd <= 1'b1; // R15
            end else if (txCnt_q != 16'h0) begin
                txCnt_q <= txCnt_q - 1'b1;
            end else if (txBit_q == TX_LAST_BIT) begin
                txBusy_q <= 1'b0;
                txDone_q <= 1'b1;
            end else begin
                txd <= txSh_q[0];
                txSh_q <= {1'b1, txSh_q[8:1]};
                txBit_q <= txBit_q + 1'b1;
                txCnt_q <= div_q - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign ctsEdge = (ctsHigh != ctsPrev_q);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctsPrev_q <= 1'b1;
            deltaCts_q <= 1'b0;
        end else begin
            ctsPrev_q <= ctsHigh;
            if (ctsEdge) begin
                deltaCts_q <= 1'b1; // R13
            end else if (rdEn && paddr == OFF_MODEM_STATUS) begin
                deltaCts_q <= 1'b0;
            end
        end
    end

    always_comb begin
        irqEvent = '0;
        irqEvent[IRQ_RX] = rxPush;
        irqEvent[IRQ_TX] = txDone_q;
        irqEvent[IRQ_MODEM] = ctsEdge && (!autoCts_q || ctsIrqEn_q); // R12 R14
        irqEvent[IRQ_OVERRUN] = rxOverrun;
    end

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus_q <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            if (wrEn && paddr == OFF_IRQ_CLEAR) begin
                irqStatus_q <= (irqStatus_q & ~pwdata[NIRQ-1:0]) | irqEvent;
            end else begin
                irqStatus_q <= irqStatus_q | irqEvent;
            end
            irq <= |(irqStatus_q & irqEn_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_auto_rts_reset;
        @(posedge mclk) $fell(sys_rst) |-> !autoRts_q && !autoCts_q;
    endproperty
    a_auto_rts_reset: assert property (p_auto_rts_reset) else $error("flow bits not zero"); // R1 R2

    property p_rts_deassert;
        @(posedge mclk) disable iff (sys_rst)
            autoRts_q && rxCount_q >= CW'(TRIG_LEVEL[trigSel_q]) |=> ##1 rtsN;
    endproperty
    a_rts_deassert: assert property (p_rts_deassert) else $error("RTS not raised"); // R4

    property p_rts_reassert;
        @(posedge mclk) disable iff (sys_rst)
            autoRts_q && rxCount_q <= CW'(TRIG_PREV[trigSel_q]) |=> !rtsOff_q;
    endproperty
    a_rts_reassert: assert property (p_rts_reassert) else $error("RTS not lowered"); // R5

    property p_late_byte_kept;
        @(posedge mclk) disable iff (sys_rst)
            rxDone_q && rtsOff_q && !fifoFull && !rxPop |=> rxCount_q == $past(rxCount_q) + 1'b1;
    endproperty
    a_late_byte_kept: assert property (p_late_byte_kept) else $error("late byte lost"); // R6

    property p_manual_rts;
        @(posedge mclk) disable iff (sys_rst)
            !autoRts_q |=> rtsN == !$past(rtsCtrl_q);
    endproperty
    a_manual_rts: assert property (p_manual_rts) else $error("RTS pin not software driven"); // R7

    property p_rts_mirror;
        @(posedge mclk) disable iff (sys_rst)
            autoRts_q ##1 autoRts_q |-> rtsCtrl_q == !rtsN;
    endproperty
    a_rts_mirror: assert property (p_rts_mirror) else $error("RTS bit does not mirror pin"); // R8

    property p_rts_write_ignored;
        @(posedge mclk) disable iff (sys_rst)
            wrEn && paddr == OFF_MODEM_CTRL && autoRts_q |=> rtsCtrl_q == !$past(rtsOff_q);
    endproperty
    a_rts_write_ignored: assert property (p_rts_write_ignored) else $error("RTS write taken"); // R9

    property p_cts_gate;
        @(posedge mclk) disable iff (sys_rst)
            $rose(txBusy_q) && $past(autoCts_q) |-> !$past(ctsHigh);
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("sent while CTS high"); // R10

    property p_cts_no_irq;
        @(posedge mclk) disable iff (sys_rst)
            ctsEdge && autoCts_q && !ctsIrqEn_q && !irqStatus_q[IRQ_MODEM] |=> !irqStatus_q[IRQ_MODEM];
    endproperty
    a_cts_no_irq: assert property (p_cts_no_irq) else $error("CTS change interrupted"); // R12 R14

    property p_delta_cts;
        @(posedge mclk) disable iff (sys_rst)
            ctsEdge |=> deltaCts_q;
    endproperty
    a_delta_cts: assert property (p_delta_cts) else $error("delta CTS not set"); // R13

    property p_idle_mark;
        @(posedge mclk) disable iff (sys_rst)
            !txBusy_q ##1 !txBusy_q |-> txd;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("line not marking while idle"); // R15

    property p_cts_ignored;
        @(posedge mclk) disable iff (sys_rst)
            txFull_q && !txBusy_q && !autoCts_q |=> txBusy_q && !txd;
    endproperty
    a_cts_ignored: assert property (p_cts_ignored) else $error("pending data not sent"); // R16

    c_rts_cycle: cover property (@(posedge mclk) disable iff (sys_rst) $rose(rtsOff_q) ##[1:1000] $fell(rtsOff_q));
    c_cts_stall: cover property (@(posedge mclk) disable iff (sys_rst) txFull_q && !txBusy_q && autoCts_q && ctsHigh);
    c_irq: cover property (@(posedge mclk) disable iff (sys_rst) $rose(irq));
endmodule

// ---- testbench/uhfc_remote.sv ----
`timescale 1ns/1ps
module uhfc_remote #(
    parameter int DIV = 16
) (
    input wire logic mclk,
    input wire logic txd,
    input wire logic rtsN,
    output logic rxd,
    output logic ctsN
);
    logic [7:0] got [$];
    logic [7:0] b;
    // Counts frames begun while the device was already asking the sender to pause.
    int lateCount = 0;

    initial begin
        rxd = 1'b1;
        ctsN = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sends one frame: start, eight data bits LSB first, stop; the line then rests at one.
    task automatic send_byte(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        if (rtsN === 1'b1) begin
            lateCount++;
        end
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (DIV) @(posedge mclk);
        end
    endtask

    // The bench only calls this while the device line is idle, well before any stop bit.
    task automatic set_cts(input logic v);
        ctsN <= v;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Decodes frames from the device at mid bit and keeps those with a valid stop bit.
    always begin
        @(negedge txd);
        repeat (DIV / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge mclk);
            b[i] = txd;
        end
        repeat (DIV) @(posedge mclk);
        if (txd === 1'b1) begin
            got.push_back(b);
        end
    end
endmodule

// ---- testbench/uhfc_flow_uart_tb.sv ----
`timescale 1ns/1ps
module uhfc_flow_uart_tb
    import uhfc_pkg::*;
;
    localparam int DIV = 16;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd;
    logic ctsN;
    logic rtsN;
    logic irq;
    int badCount = 0;
    int checks = 0;

    always #2.5 mclk = ~mclk;

    uhfc_flow_uart #(.DEPTH(16)) DUT (.mclk(mclk), .sys_rst(sysRst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .ctsN(ctsN), .rtsN(rtsN),
        .irq(irq));
    uhfc_remote #(.DIV(DIV)) rem (.mclk(mclk), .txd(txd), .rtsN(rtsN), .rxd(rxd), .ctsN(ctsN));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", w, e, g);
            badCount++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            $display("Error apb pready expected 1 seen %b", pready);
            badCount++;
            giveVerdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string w);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 32'h0, r, er);
        chk(w, e, r & m);
    endtask

    task automatic wait_rx(output logic [7:0] v);
        int n;
        n = 0;
        while (rem.got.size() == 0 && n < 20 * DIV) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20 * DIV) begin
            $display("Error rx frame expected 1 seen 0");
            badCount++;
            giveVerdict();
        end
        v = rem.got.pop_front();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic er;
        chk("rtsN", 32'h1, 32'(rtsN));
        chk("txd", 32'h1, 32'(txd));
        rdc(OFF_MODEM_CTRL, 32'hc2, 32'h0, "mcr reset");
        wr(OFF_MODEM_CTRL, 32'h02);
        cyc(3);
        chk("rtsN manual", 32'h0, 32'(rtsN));
        wr(OFF_MODEM_CTRL, 32'h00);
        cyc(3);
        chk("rtsN manual", 32'h1, 32'(rtsN));
        apb(1'b0, 8'h30, 32'h0, r, er);
        chk("pslverr", 32'h1, 32'(er));
        chk("unmapped", 32'h0, r);
        $display("test reset done");
    endtask

    task automatic t_auto_rts();
        wr(OFF_DIVISOR, DIV);
        wr(OFF_FIFO_CTRL, 32'h40);
        wr(OFF_MODEM_CTRL, 32'h40);
        cyc(3);
        chk("rtsN auto", 32'h0, 32'(rtsN));
        for (int i = 1; i <= 4; i++) begin
            rem.send_byte(8'(8'h10 + i));
        end
        cyc(2);
        chk("rtsN at trigger", 32'h1, 32'(rtsN));
        rdc(OFF_MODEM_CTRL, 32'h02, 32'h00, "mcr rts mirror");
        wr(OFF_MODEM_CTRL, 32'h42);
        cyc(3);
        chk("rtsN write ignored", 32'h1, 32'(rtsN));
        rem.send_byte(8'h15);
        cyc(2);
        chk("late starts", 32'h1, 32'(rem.lateCount));
        rdc(OFF_RX_LEVEL, 32'h1f, 32'h5, "extra byte");
        for (int i = 1; i <= 3; i++) begin
            rdc(OFF_DATA, 32'hff, 32'(8'h10 + i), "rx data");
        end
        cyc(3);
        chk("rtsN hysteresis", 32'h1, 32'(rtsN));
        rdc(OFF_DATA, 32'hff, 32'h14, "rx data");
        cyc(3);
        chk("rtsN reassert", 32'h0, 32'(rtsN));
        rdc(OFF_MODEM_CTRL, 32'h02, 32'h02, "mcr rts mirror");
        rdc(OFF_DATA, 32'hff, 32'h15, "rx data");
        wr(OFF_MODEM_CTRL, 32'h00);
        $display("test auto rts done");
    endtask

    task automatic t_auto_cts();
        logic [7:0] v;
        int low;
        wr(OFF_MODEM_CTRL, 32'h80);
        rdc(OFF_MODEM_STATUS, 32'h10, 32'h00, "cts state");
        wr(OFF_IRQ_ENABLE, 32'(1 << IRQ_MODEM));
        wr(OFF_CTS_IRQ_CTRL, 32'h0);
        wr(OFF_IRQ_CLEAR, 32'hf);
        wr(OFF_DATA, 32'h5a);
        low = 0;
        for (int i = 0; i < 3 * DIV; i++) begin
            @(posedge mclk);
            low += (txd !== 1'b1);
        end
        chk("txd held", 32'h0, 32'(low));
        rem.set_cts(1'b0);
        wait_rx(v);
        chk("tx after cts", 32'h5a, 32'(v));
        rdc(OFF_MODEM_STATUS, 32'h11, 32'h11, "delta cts");
        chk("irq quiet", 32'h0, 32'(irq));
        rdc(OFF_IRQ_STATUS, 32'h4, 32'h0, "modem irq");
        wr(OFF_CTS_IRQ_CTRL, 32'h1);
        rem.set_cts(1'b1);
        cyc(5);
        chk("irq on", 32'h1, 32'(irq));
        wr(OFF_IRQ_ENABLE, 32'h0);
        cyc(2);
        chk("irq masked", 32'h0, 32'(irq));
        wr(OFF_IRQ_CLEAR, 32'h4);
        rdc(OFF_IRQ_STATUS, 32'h4, 32'h0, "irq cleared");
        rdc(OFF_MODEM_STATUS, 32'h11, 32'h01, "delta cts");
        $display("test auto cts done");
    endtask

    task automatic t_no_cts();
        logic [7:0] v;
        wr(OFF_MODEM_CTRL, 32'h00);
        wr(OFF_DATA, 32'ha5);
        wait_rx(v);
        chk("tx cts ignored", 32'ha5, 32'(v));
        $display("test no cts done");
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        sysRst <= 1'b0;
        cyc(3);
        t_reset();
        t_auto_rts();
        t_auto_cts();
        t_no_cts();
        giveVerdict();
    end
endmodule
